// *** flash_cmd_pkg.sv ***
package flash_cmd_pkg;
   // ********************
   // Command opcodes
   // ********************
   localparam logic [7:0] OP_READ_MAKER = 8'h90;
   localparam logic [7:0] OP_READ_UNIQUE = 8'h4b;
   localparam logic [7:0] OP_READ_PARAM = 8'h5a;
   localparam logic [7:0] OP_NO_OPERATION = 8'h00;
   localparam logic [7:0] OP_RESET_ARM = 8'h66;
   localparam logic [7:0] OP_RESET = 8'h99;
   localparam logic [7:0] OP_ROW_ERASE = 8'h64;
   localparam logic [7:0] OP_ROW_PROGRAM = 8'h62;

   // ********************
   // Frame layout
   // ********************
   localparam logic [2:0] LAST_BIT = 3'h7;
   localparam logic [2:0] POS_MAX = 3'h5;
   localparam logic [2:0] POS_ADDR_LO = 3'h3;
   localparam logic [2:0] POS_DATA = 3'h4;
   localparam logic [2:0] HDR_ID_BYTES = 3'h4;
   localparam logic [2:0] HDR_READ_BYTES = 3'h5;

   // ********************
   // Security rows
   // ********************
   localparam logic [7:0] ROW_UPPER = 8'h00;
   localparam logic [7:0] ROW_MID_MASK = 8'hcf;
   localparam int ROW_SEL_LSB = 12;
   localparam int ROWS = 4;
   localparam int ROW_BYTES = 256;
   localparam logic [7:0] ERASED_BYTE = 8'hff;
   localparam logic [4:0] UID_ZERO = 5'h00;
   localparam int UID_BYTES = 16;
   localparam int PARAM_BYTES = 16;
   localparam logic [7:0] UNDEF_BYTE = 8'hff;

   // ********************
   // Timing
   // ********************
   localparam int CLK_PERIOD_NS = 40;
   localparam int HW_RESET_MIN_NS = 1000;
   localparam int HW_RESET_MIN_CYC = (HW_RESET_MIN_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;

   // ********************
   // Types
   // ********************
   typedef struct packed {
      logic [2:0] pos;
      logic [7:0] data;
   } byte_event_t;

   typedef struct packed {
      logic operation_in_progress;
      logic write_enable_latch;
      logic software_reset_arm;
      logic hw_reset_active;
   } status_t;

   typedef enum logic [1:0] {OP_IDLE, OP_PROGRAM, OP_ERASE} op_state_t;
endpackage

// *** flash_cmd_core.sv ***
module flash_cmd_core
   import flash_cmd_pkg::*;
#(
   parameter logic [7:0] maker_code_p = 8'ha5, // arbitrary value
   parameter logic [7:0] part_code_p = 8'h3c, // arbitrary value
   parameter logic [127:0] unique_number_p = 128'h0123456789abcdef_fedcba9876543210,
   parameter logic [127:0] param_table_p = 128'h0,
   parameter logic [7:0] write_enable_opcode_p = 8'h06,
   parameter logic [15:0] prog_cycles_p = 16'h00c8,
   parameter logic [15:0] erase_cycles_p = 16'h0190
)
(
   // System clock and reset
   input wire logic clk_sys_in,
   input wire logic rst_in,
   // Serial link
   input wire logic sck_in,
   input wire logic cs_n_in,
   input wire logic si_in,
   output logic so_out,
   output logic so_oe_out,
   // Reset pin
   input wire logic reset_n_in,
   // Configuration
   input wire logic quad_mode_in,
   input wire logic quad_enable_in,
   input wire logic [3:0] lock_bits_in,
   input wire logic [7:0] nv_read_param_in,
   // Status
   output status_t status_out,
   output logic [7:0] read_param_out,
   // Row readback
   input wire logic [9:0] row_rd_addr_in,
   output logic [7:0] row_rd_data_out
);

   // ********************
   // Link domain
   // ********************
   logic [2:0] bit_cnt_r;
   logic [2:0] pos_r;
   logic [7:0] dat_idx_r;
   logic [6:0] shin_r;
   logic [7:0] opcode_r;
   logic [23:0] addr_r;
   logic ev_tgl_r;
   byte_event_t ev_r;
   logic [1:0] busy_l1_r;
   logic [1:0] busy_l2_r;
   logic so_r;
   logic oe_r;
   // Pin reset state lives in the system domain but gates the link output
   logic hw_active_r;
   logic [7:0] rx_byte;
   logic data_phase;
   logic read_cmd;
   logic [7:0] tx_byte;
   logic [3:0] uid_idx;
   logic [7:0] par_idx;

   assign rx_byte = {shin_r, si_in};

   // Header length depends on the command
   // ID header length
   assign data_phase = pos_r >= ((opcode_r == OP_READ_MAKER) ? HDR_ID_BYTES : HDR_READ_BYTES);
   assign read_cmd = (opcode_r == OP_READ_MAKER) || (opcode_r == OP_READ_UNIQUE)
      || (opcode_r == OP_READ_PARAM);

   assign uid_idx = addr_r[3:0] + dat_idx_r[3:0];
   assign par_idx = addr_r[7:0] + dat_idx_r;

   // Byte to shift out for the running read
   always_comb
   begin
      tx_byte = UNDEF_BYTE;
      case (opcode_r)
         OP_READ_MAKER:
            tx_byte = (addr_r[0] ^ dat_idx_r[0]) ? part_code_p : maker_code_p;
         OP_READ_UNIQUE:
            if (addr_r[8:4] == UID_ZERO)
               tx_byte = unique_number_p[(UID_BYTES - 1 - int'(uid_idx)) * 8 +: 8];
         OP_READ_PARAM:
            if (addr_r[23:8] == 16'h0000 && int'(par_idx) < PARAM_BYTES)
               tx_byte = param_table_p[(PARAM_BYTES - 1 - int'(par_idx)) * 8 +: 8];
         default:
            tx_byte = UNDEF_BYTE;
      endcase
   end

   // Frame counters, cleared whenever the chip is deselected
   always_ff @(posedge sck_in or posedge cs_n_in)
   begin
      if (cs_n_in)
      begin
         bit_cnt_r <= '0;
         pos_r <= '0;
         dat_idx_r <= '0;
      end
      else
      begin
         bit_cnt_r <= bit_cnt_r + 3'h1;
         if (bit_cnt_r == LAST_BIT && pos_r != POS_MAX)
            pos_r <= pos_r + 3'h1;
         if (bit_cnt_r == LAST_BIT && data_phase)
            dat_idx_r <= dat_idx_r + 8'h01;
      end
   end

   // sample on rising edge
   // Not cleared by deselect: the last byte must survive the frame end
   always_ff @(posedge sck_in)
   begin
      shin_r <= rx_byte[6:0];
      if (bit_cnt_r == LAST_BIT && !cs_n_in && !busy_l2_r[0])
      begin
         if (pos_r == '0)
            opcode_r <= rx_byte;
         if (pos_r != '0 && pos_r < POS_DATA)
            addr_r <= {addr_r[15:0], rx_byte};
         ev_r <= '{pos: pos_r, data: rx_byte};
      end
   end

   // Byte event toggle; data stays put for eight link clocks
   always_ff @(posedge sck_in or posedge rst_in)
   begin
      if (rst_in)
         ev_tgl_r <= 1'b0;
      else if (bit_cnt_r == LAST_BIT && !cs_n_in && !busy_l2_r[0])
         ev_tgl_r <= ~ev_tgl_r;
   end

   // Busy and pin reset levels into the link domain
   always_ff @(posedge sck_in)
   begin
      busy_l1_r <= {status_out.operation_in_progress, status_out.hw_reset_active};
      busy_l2_r <= busy_l1_r;
   end

   always_ff @(negedge sck_in or posedge cs_n_in)
   begin
      if (cs_n_in)
      begin
         so_r <= 1'b0;
         oe_r <= 1'b0;
      end
      else
      begin
         so_r <= tx_byte[~bit_cnt_r];
         oe_r <= read_cmd && data_phase && busy_l2_r == 2'b00;
      end
   end

   // tristate at once on pin reset
   assign so_out = so_r;
   assign so_oe_out = oe_r && !hw_active_r;

   // ********************
   // System domain
   // ********************
   logic [2:0] cs_sync_r;
   logic [2:0] ev_sync_r;
   logic [1:0] pin_sync_r;
   byte_event_t ev_sys;
   logic ev_fire;
   logic frame_end;
   logic [7:0] cmd_op_r;
   logic [23:0] cmd_addr_r;
   logic [7:0] wptr_r;
   logic data_seen_r;
   logic wel_r;
   logic arm_r;
   logic [4:0] hw_cnt_r;
   logic [7:0] read_param_r;
   op_state_t op_state_r;
   logic [15:0] op_cnt_r;
   logic [1:0] op_row_r;
   logic [7:0] row_rd_data_r;
   logic accept;
   logic op_idle;
   logic row_ok;
   logic [1:0] row_sel;
   logic soft_rst;
   logic abort;
   logic store_en;
   logic start_prog;
   logic start_erase;
   logic done_prog;
   logic done_erase;
   logic [7:0] buf_r [ROW_BYTES];
   logic [ROW_BYTES-1:0] mask_r;
   logic [7:0] mem_r [ROWS][ROW_BYTES];

   // Edge detects look only at the second and third flops
   always_ff @(posedge clk_sys_in)
   begin
      if (rst_in)
      begin
         cs_sync_r <= 3'h7;
         ev_sync_r <= '0;
         pin_sync_r <= 2'h3;
      end
      else
      begin
         cs_sync_r <= {cs_sync_r[1:0], cs_n_in};
         ev_sync_r <= {ev_sync_r[1:0], ev_tgl_r};
         pin_sync_r <= {pin_sync_r[0], reset_n_in};
      end
   end

   assign ev_sys = ev_r;
   assign ev_fire = (ev_sync_r[1] ^ ev_sync_r[2]) && !hw_active_r;
   assign frame_end = cs_sync_r[1] && !cs_sync_r[2] && !hw_active_r;
   assign op_idle = op_state_r == OP_IDLE;

   assign accept = frame_end && op_state_r != OP_PROGRAM;

   assign row_ok = cmd_addr_r[23:16] == ROW_UPPER && (cmd_addr_r[15:8] & ROW_MID_MASK) == 8'h00;
   assign row_sel = cmd_addr_r[ROW_SEL_LSB +: 2];

   assign soft_rst = accept && cmd_op_r == OP_RESET && arm_r;
   assign abort = hw_active_r || soft_rst;

   // no new row command while busy
   assign start_prog = accept && op_idle && cmd_op_r == OP_ROW_PROGRAM && wel_r
      && row_ok && !lock_bits_in[row_sel] && data_seen_r;
   assign start_erase = accept && op_idle && cmd_op_r == OP_ROW_ERASE && wel_r
      && row_ok && !lock_bits_in[row_sel];
   assign store_en = ev_fire && ev_sys.pos >= POS_DATA && cmd_op_r == OP_ROW_PROGRAM && op_idle;
   assign done_prog = op_state_r == OP_PROGRAM && op_cnt_r == '0 && !abort;
   assign done_erase = op_state_r == OP_ERASE && op_cnt_r == '0 && !abort;

   // Command bytes as they arrive from the link
   always_ff @(posedge clk_sys_in)
   begin
      if (rst_in)
      begin
         cmd_op_r <= OP_NO_OPERATION;
         cmd_addr_r <= '0;
         wptr_r <= '0;
         data_seen_r <= 1'b0;
      end
      else if (ev_fire && op_state_r != OP_PROGRAM)
      begin
         if (ev_sys.pos == '0)
         begin
            cmd_op_r <= ev_sys.data;
            data_seen_r <= 1'b0;
         end
         else if (ev_sys.pos < POS_DATA)
            cmd_addr_r <= {cmd_addr_r[15:0], ev_sys.data};
         if (ev_sys.pos == POS_ADDR_LO)
            wptr_r <= ev_sys.data;
         if (store_en)
         begin
            wptr_r <= wptr_r + 8'h01;
            data_seen_r <= 1'b1;
         end
      end
   end

   // Reset arm: any accepted frame other than 66h drops it
   always_ff @(posedge clk_sys_in)
   begin
      if (rst_in || hw_active_r)
         arm_r <= 1'b0;
      else if (accept)
         arm_r <= cmd_op_r == OP_RESET_ARM;
   end

   // Write enable latch
   always_ff @(posedge clk_sys_in)
   begin
      if (rst_in || abort || done_prog || done_erase)
         wel_r <= 1'b0;
      else if (accept && op_idle && cmd_op_r == write_enable_opcode_p)
         wel_r <= 1'b1;
   end

   always_ff @(posedge clk_sys_in)
   begin
      if (rst_in || hw_active_r)
         read_param_r <= '0;
      else if (soft_rst)
         read_param_r <= nv_read_param_in;
   end

   always_ff @(posedge clk_sys_in)
   begin
      if (rst_in || pin_sync_r[1] || quad_mode_in || quad_enable_in)
      begin
         hw_cnt_r <= '0;
         hw_active_r <= 1'b0;
      end
      else if (int'(hw_cnt_r) < HW_RESET_MIN_CYC - 1)
         hw_cnt_r <= hw_cnt_r + 5'h01;
      else
         hw_active_r <= 1'b1;
   end

   // Program and erase sequencer
   always_ff @(posedge clk_sys_in)
   begin
      if (rst_in || abort)
      begin
         op_state_r <= OP_IDLE;
         op_cnt_r <= '0;
      end
      else
      begin
         case (op_state_r)
            OP_IDLE:
            begin
               op_row_r <= row_sel;
               if (start_prog)
               begin
                  op_state_r <= OP_PROGRAM;
                  op_cnt_r <= prog_cycles_p;
               end
               else if (start_erase)
               begin
                  op_state_r <= OP_ERASE;
                  op_cnt_r <= erase_cycles_p;
               end
            end
            OP_PROGRAM, OP_ERASE:
            begin
               op_cnt_r <= op_cnt_r - 16'h0001;
               if (op_cnt_r == '0)
                  op_state_r <= OP_IDLE;
            end
            default:
               op_state_r <= OP_IDLE;
         endcase
      end
   end

   // Page buffer, written mask and row storage per byte position
   for (genvar i = 0; i < ROW_BYTES; i++)
   begin : g_entry
      always_ff @(posedge clk_sys_in)
      begin
         if (rst_in || (ev_fire && ev_sys.pos == '0 && op_idle))
            mask_r[i] <= 1'b0;
         // last byte at a slot kept
         else if (store_en && wptr_r == 8'(i))
         begin
            mask_r[i] <= 1'b1;
            buf_r[i] <= ev_sys.data;
         end
      end

      for (genvar r = 0; r < ROWS; r++)
      begin : g_row
         always_ff @(posedge clk_sys_in)
         begin
            if (rst_in)
               mem_r[r][i] <= ERASED_BYTE;
            else if (done_erase && op_row_r == 2'(r))
               mem_r[r][i] <= ERASED_BYTE;
            else if (done_prog && op_row_r == 2'(r) && mask_r[i])
               mem_r[r][i] <= mem_r[r][i] & buf_r[i];
         end
      end
   end

   // Row readback
   always_ff @(posedge clk_sys_in)
   begin
      if (rst_in)
         row_rd_data_r <= '0;
      else
         row_rd_data_r <= mem_r[row_rd_addr_in[9:8]][row_rd_addr_in[7:0]];
   end

   assign row_rd_data_out = row_rd_data_r;
   assign read_param_out = read_param_r;

   assign status_out = '{operation_in_progress: !op_idle, write_enable_latch: wel_r,
                         software_reset_arm: arm_r, hw_reset_active: hw_active_r};

endmodule

// *** flash_cmd_asserts.sv ***
module flash_cmd_asserts
   import flash_cmd_pkg::*;
(
   // Clock and reset
   input wire logic clk_sys_in,
   input wire logic rst_in,
   // Watched ports
   input wire logic cs_n_in,
   input wire logic quad_mode_in,
   input wire logic quad_enable_in,
   input wire logic so_oe_out,
   input wire status_t status_out,
   input wire logic [7:0] read_param_out
);
   // ********************
   // Port relations
   // ********************
   default clocking cb @(posedge clk_sys_in);
   endclocking
   default disable iff (rst_in);

   a_oe_needs_select: assert property (cs_n_in |-> !so_oe_out)
      else $error("serial out driven while deselected");
   a_busy_no_drive: assert property (status_out.operation_in_progress |-> !so_oe_out)
      else $error("serial out driven while busy");
   a_hw_no_drive: assert property (status_out.hw_reset_active |-> !so_oe_out)
      else $error("serial out driven during pin reset");
   a_hw_clears: assert property (status_out.hw_reset_active && $past(status_out.hw_reset_active)
      |-> !status_out.write_enable_latch && !status_out.software_reset_arm
      && !status_out.operation_in_progress && read_param_out == 8'h00)
      else $error("pin reset left state behind");
   a_quad_blocks: assert property ($rose(status_out.hw_reset_active)
      |-> !$past(quad_mode_in) && !$past(quad_enable_in))
      else $error("pin reset honoured in quad setup");
   a_param_cause: assert property ($changed(read_param_out) |-> $past(status_out.software_reset_arm)
      || $past(status_out.software_reset_arm, 2) || status_out.hw_reset_active
      || $past(status_out.hw_reset_active))
      else $error("read parameters changed without reset");
   a_busy_latch: assert property ($rose(status_out.operation_in_progress)
      |-> $past(status_out.write_enable_latch))
      else $error("operation started without latch");
   a_done_latch: assert property ($fell(status_out.operation_in_progress)
      |-> ##[0:1] !status_out.write_enable_latch)
      else $error("latch kept after completion");
endmodule

bind flash_cmd_core flash_cmd_asserts u_chk (.clk_sys_in(clk_sys_in), .rst_in(rst_in),
   .cs_n_in(cs_n_in), .quad_mode_in(quad_mode_in), .quad_enable_in(quad_enable_in),
   .so_oe_out(so_oe_out), .status_out(status_out), .read_param_out(read_param_out));

// *** spi_host_model.sv ***
module spi_host_model
(
   // Link pins
   output logic sck_out,
   output logic cs_n_out,
   output logic si_out,
   input wire logic so_in
);
   timeunit 1ns;
   timeprecision 100ps;

   // ********************
   // Framed transfers
   // ********************
   logic [7:0] rx_q[$];

   // Clock parked low between frames
   initial
   begin
      sck_out = 1'b0;
      cs_n_out = 1'b1;
      si_out = 1'b0;
   end

   // header out, reply sampled on rise
   task automatic run(input logic [7:0] tx[$], input int nrx);
      logic [7:0] b;
      logic [7:0] r;
      rx_q = {};
      cs_n_out = 1'b0;
      for (int i = 0; i < tx.size() + nrx; i++)
      begin
         b = (i < tx.size()) ? tx[i] : 8'h00;
         for (int k = 7; k >= 0; k--)
         begin
            si_out = b[k];
            #24 sck_out = 1'b1;
            r = {r[6:0], so_in};
            #24 sck_out = 1'b0;
         end
         if (i >= tx.size())
            rx_q.push_back(r);
      end
      #24 cs_n_out = 1'b1;
      si_out = ~si_out; // Released line must not keep its value
   endtask
endmodule

// *** flash_id_reset_info_row_cmds_bench.sv ***
module flash_id_reset_info_row_cmds_bench;
   import flash_cmd_pkg::*;
   timeunit 1ns;
   timeprecision 100ps;

   // ********************
   // Bench setup
   // ********************
   localparam logic [7:0] MK = 8'ha5; // arbitrary value
   localparam logic [7:0] PT = 8'h3c; // arbitrary value
   localparam logic [7:0] WEN = 8'h06;
   localparam logic [127:0] UID = 128'h0123456789abcdef_fedcba9876543210;
   localparam logic [127:0] TBL = 128'h5346445001020304_a1b2c3d4e5f60718;
   logic clk_sys_in, rst_in, sck, cs_n, si, so, so_oe, reset_n, quad_mode, quad_en;
   logic [3:0] lock_bits;
   logic [7:0] nv_param, read_param, row_data;
   logic [9:0] row_addr;
   status_t status;
   int fail_count = 0;
   int total_checks = 0;

   // Free-running system clock
   initial
   begin
      clk_sys_in = 1'b0;
      forever #20 clk_sys_in = ~clk_sys_in;
   end

   // Short busy times keep the run brief
   flash_cmd_core #(.maker_code_p(MK), .part_code_p(PT), .unique_number_p(UID),
      .param_table_p(TBL), .write_enable_opcode_p(WEN), .prog_cycles_p(16'h0006),
      .erase_cycles_p(16'h0064)) u_dut (.clk_sys_in(clk_sys_in), .rst_in(rst_in),
      .sck_in(sck), .cs_n_in(cs_n), .si_in(si), .so_out(so), .so_oe_out(so_oe),
      .reset_n_in(reset_n), .quad_mode_in(quad_mode), .quad_enable_in(quad_en),
      .lock_bits_in(lock_bits), .nv_read_param_in(nv_param), .status_out(status),
      .read_param_out(read_param), .row_rd_addr_in(row_addr), .row_rd_data_out(row_data));

   spi_host_model u_host (.sck_out(sck), .cs_n_out(cs_n), .si_out(si), .so_in(so));

   task automatic give_verdict();
      $display("checks %0d mismatches %0d", total_checks, fail_count);
      if (fail_count == 0 && total_checks > 0)
         $display("Test passed");
      else
         $display("Test failed");
      $finish;
   endtask

   task automatic chk(input string what, input logic [7:0] exp, input logic [7:0] got);
      total_checks++;
      if (got !== exp)
      begin
         fail_count++;
         $display("MISMATCH %s expected %h seen %h", what, exp, got);
      end
   endtask

   // Frame plus the deselect gap the core needs
   task automatic frame(input logic [7:0] tx[$], input int nrx);
      u_host.run(tx, nrx);
      repeat (8) @(posedge clk_sys_in);
   endtask

   task automatic cmd(input logic [7:0] op);
      logic [7:0] q[$];
      q = {op};
      frame(q, 0);
   endtask

   task automatic rd(input logic [7:0] op, input logic [23:0] a, input int nrx);
      logic [7:0] q[$];
      q = {op, a[23:16], a[15:8], a[7:0], 8'h00};
      if (op == OP_READ_MAKER)
         q = {op, 8'h00, 8'h00, a[7:0]};
      frame(q, nrx);
   endtask

   // Write enable, then row command with up to two data bytes
   task automatic wr(input logic [7:0] op, input logic [7:0] mid, input logic [7:0] lo,
      input logic [7:0] d0, input int nd);
      logic [7:0] q[$];
      cmd(WEN);
      q = {op, 8'h00, mid, lo};
      if (nd > 0)
         q.push_back(d0);
      if (nd > 1)
         q.push_back(~d0);
      frame(q, 0);
   endtask

   task automatic wait_idle();
      for (int i = 0; i < 400 && status.operation_in_progress !== 1'b0; i++)
         @(posedge clk_sys_in);
      chk("busy", 8'h00, {7'h0, status.operation_in_progress});
   endtask

   task automatic row_chk(input logic [9:0] a, input logic [7:0] exp);
      row_addr <= a;
      repeat (3) @(posedge clk_sys_in);
      chk("row byte", exp, row_data);
   endtask

   // Pin held low well past the minimum pulse
   task automatic pin_pulse(input logic exp);
      reset_n <= 1'b0;
      repeat (30) @(posedge clk_sys_in);
      chk("hw reset", {7'h0, exp}, {7'h0, status.hw_reset_active});
      chk("params", exp ? 8'h00 : 8'h5c, read_param);
      reset_n <= 1'b1;
      repeat (2500) @(posedge clk_sys_in);
   endtask

   // Hang guard, far beyond the expected run time
   initial
   begin
      #1000000;
      fail_count++;
      give_verdict();
   end

   // ********************
   // Test sequence
   // ********************
   initial
   begin
      rst_in = 1'b1;
      reset_n = 1'b1;
      quad_mode = 1'b0;
      quad_en = 1'b0;
      lock_bits = 4'h0;
      nv_param = 8'h5c;
      row_addr = 10'h000;
      repeat (3) @(posedge clk_sys_in);
      rst_in <= 1'b0;
      repeat (6) @(posedge clk_sys_in);
      for (int a = 0; a < 2; a++)
      begin
         rd(OP_READ_MAKER, 24'(a), 4);
         for (int k = 0; k < 4; k++)
            chk("id byte", ((a ^ k) & 1) ? PT : MK, u_host.rx_q[k]);
      end
      rd(OP_READ_UNIQUE, 24'hfe000e, 4);
      for (int k = 0; k < 4; k++)
         chk("uid byte", UID[127 - 8 * ((14 + k) % 16) -: 8], u_host.rx_q[k]);
      rd(OP_READ_PARAM, 24'h00000e, 2);
      for (int k = 0; k < 2; k++)
         chk("table byte", TBL[127 - 8 * (14 + k) -: 8], u_host.rx_q[k]);
      wr(OP_ROW_PROGRAM, 8'h10, 8'hff, 8'haa, 2);
      wait_idle();
      row_chk(10'h1ff, 8'haa);
      row_chk(10'h100, 8'h55);
      row_chk(10'h101, 8'hff);
      chk("latch", 8'h00, {7'h0, status.write_enable_latch});
      wr(OP_ROW_PROGRAM, 8'h10, 8'hff, 8'h0f, 1);
      wait_idle();
      row_chk(10'h1ff, 8'h0a);
      lock_bits <= 4'h2;
      wr(OP_ROW_PROGRAM, 8'h10, 8'h01, 8'h00, 1);
      wait_idle();
      row_chk(10'h101, 8'hff);
      lock_bits <= 4'h0;
      wr(OP_ROW_ERASE, 8'h10, 8'h00, 8'h00, 0);
      wr(OP_ROW_PROGRAM, 8'h00, 8'h00, 8'h00, 1);
      wait_idle();
      row_chk(10'h1ff, 8'hff);
      row_chk(10'h000, 8'hff);
      chk("params", 8'h00, read_param);
      cmd(OP_RESET_ARM);
      chk("arm", 8'h01, {7'h0, status.software_reset_arm});
      cmd(OP_RESET);
      chk("params", 8'h5c, read_param);
      nv_param <= 8'h3a;
      cmd(OP_RESET_ARM);
      cmd(OP_NO_OPERATION);
      chk("arm", 8'h00, {7'h0, status.software_reset_arm});
      cmd(OP_RESET);
      chk("params", 8'h5c, read_param);
      nv_param <= 8'h5c;
      quad_en <= 1'b1;
      pin_pulse(1'b0);
      quad_en <= 1'b0;
      pin_pulse(1'b1);
      give_verdict();
   end
endmodule
